// ### bcr_defs.svh
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// Reset values
`define BCR_VBR_RESET 32'h0000_0000
`define BCR_PC_RESET 32'hA000_0000
`define BCR_ZERO 32'h0000_0000

// Status word field positions (layout chosen for this block)
`define BCR_SW_PRIV 30
`define BCR_SW_BANK 29

// Memory-mapped register windows
`define BCR_UPPER_WIN_LO 32'hFC00_0000
`define BCR_LOWER_WIN_LO 32'h1C00_0000
`define BCR_LOWER_WIN_HI 32'h1FFF_FFFF

`endif

// ### bcr_pkg.sv
package bcr_pkg;

	typedef enum logic [1:0] {
		BCR_SZ_BYTE,
		BCR_SZ_WORD,
		BCR_SZ_LONG
	} bcr_size_t;

	typedef enum logic [3:0] {
		BCR_CR_NONE,
		BCR_CR_SAVED_STATUS,
		BCR_CR_SAVED_IP,
		BCR_CR_GLOBAL_BASE,
		BCR_CR_VECTOR_BASE,
		BCR_CR_SAVED_STACK,
		BCR_CR_DEBUG_BASE,
		BCR_CR_ACC_HIGH,
		BCR_CR_ACC_LOW,
		BCR_CR_RETURN_LINK,
		BCR_CR_FP_TRANSFER,
		BCR_CR_STATUS,
		BCR_CR_ALT_BANK
	} bcr_ctrl_sel_t;

	// General register write request from the core
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [31:0] data;
	} bcr_gpr_wr_t;

	// Single-precision write; ext selects the extended single view
	typedef struct packed {
		logic en;
		logic ext;
		logic [3:0] idx;
		logic [31:0] data;
	} bcr_fpr_wr_t;

	// Control/system register write; alt_idx names a non-selected bank slot
	typedef struct packed {
		logic en;
		bcr_ctrl_sel_t sel;
		logic [2:0] alt_idx;
		logic [31:0] data;
	} bcr_ctrl_wr_t;

	// Memory access check request
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		bcr_size_t size;
	} bcr_mem_chk_t;

endpackage

// ### bcr_regfile.sv
`include "bcr_defs.svh"
// What this block does
// - Twenty-four 32-bit general registers; sixteen visible as indices 0 to 15
// - Low bank 0 visible in user mode, or privileged with bank select 0
// - Low bank 1 hidden in user mode; visible when privileged and bank select 1
// - Thirty-two 32-bit floating-point registers in two banks of sixteen
// - Single names use floating bank chosen by fp bank select
// - Extended single names always use the opposite floating bank
// - Double pair 2k is singles 2k and 2k+1
// - Vector quad 4k groups singles 4k to 4k+3
// - Extended double pair 2k is extended singles 2k and 2k+1
// - Extended matrix is all sixteen extended singles of the other bank
// - Exception or interrupt copies the status word into saved status
// - Exception or interrupt saves the faulting instruction address
// - Exception or interrupt copies general register 15 into saved stack
// - Vector base resets to zero and bases exception branch targets
// - User break with debug enable branches via debug vector base
// - Instruction pointer holds current instruction, resets to documented address
// - Subroutine calls write return link; subroutine return uses it
// - Global base supplies base for base-relative addressing forms
// - Upper register window in user mode raises address error; lower window aliases
// - Byte and word loads are sign-extended to 32 bits
// - Misaligned word or longword access raises address error
// - Comes out of reset privileged with bank select 1; exceptions switch to privileged operation
// - Protected status fields and other-bank writes only when privileged; other-bank reads through the control port are not gated
module bcr_regfile
	import bcr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire logic big_endian_strap,
	// General register ports
	input wire logic [3:0] gpr_rd_a_idx,
	input wire logic [3:0] gpr_rd_b_idx,
	output logic [31:0] gpr_rd_a,
	output logic [31:0] gpr_rd_b,
	input wire bcr_gpr_wr_t gpr_wr,
	// Floating-point ports
	input wire logic fp_bank_select,
	input wire logic [3:0] fpr_rd_idx,
	input wire logic fpr_rd_ext,
	output logic [31:0] fpr_rd,
	input wire logic [2:0] dbl_rd_idx,
	input wire logic dbl_rd_ext,
	output logic [63:0] dbl_rd,
	input wire logic [1:0] vec_rd_idx,
	output logic [127:0] vec_rd,
	output logic [511:0] extended_fp_matrix_rd,
	input wire bcr_fpr_wr_t fpr_wr,
	// Control and system registers
	input wire bcr_ctrl_wr_t ctrl_wr,
	input wire bcr_ctrl_sel_t ctrl_rd_sel,
	input wire logic [2:0] ctrl_rd_alt_idx,
	output logic [31:0] ctrl_rd,
	output logic ctrl_priv_err,
	output logic [31:0] status_word,
	// Exception entry and return
	input wire logic exc_take,
	input wire logic exc_user_break,
	input wire logic [31:0] exc_addr,
	input wire logic [31:0] exc_offset,
	output logic [31:0] exc_target,
	input wire logic exc_return,
	// Instruction flow
	input wire logic ip_load,
	input wire logic [31:0] ip_next,
	output logic [31:0] instruction_pointer,
	input wire logic call_take,
	input wire logic [31:0] call_return_addr,
	output logic [31:0] return_target,
	input wire logic user_break_debug_enable,
	// Addressing and memory checks
	input wire logic [31:0] base_disp,
	output logic [31:0] base_ea,
	input wire bcr_mem_chk_t mem_chk,
	output logic mem_addr_err,
	output logic mem_in_reg_window,
	input wire logic [31:0] load_raw,
	input wire bcr_size_t load_size,
	output logic [31:0] load_data,
	output logic big_endian
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [31:0] low_bank0 [8];
	logic [31:0] low_bank1 [8];
	logic [31:0] high_regs [8];
	logic [31:0] fpr_bank0 [16];
	logic [31:0] fpr_bank1 [16];
	logic [31:0] saved_status_copy;
	logic [31:0] saved_instruction_address;
	logic [31:0] global_base_address;
	logic [31:0] exception_vector_base;
	logic [31:0] saved_stack_pointer_copy;
	logic [31:0] debug_handler_base;
	logic [31:0] accumulator_high;
	logic [31:0] accumulator_low;
	logic [31:0] subroutine_return_address;
	logic [31:0] fp_cpu_transfer;
	logic privilege_bit;
	logic bank_select_bit;
	logic use_bank1;
	logic sel_fp1;
	logic gpr_en_b0;
	logic gpr_en_b1;
	logic [31:0] fpr_sel [16];
	logic [31:0] fpr_ext [16];
	logic [255:0] bank1_flat;

	assign privilege_bit = status_word[`BCR_SW_PRIV];
	assign bank_select_bit = status_word[`BCR_SW_BANK];
	assign use_bank1 = privilege_bit & bank_select_bit;
	assign sel_fp1 = fp_bank_select;

	// ------------------------------------------------------------
	// General registers
	// ------------------------------------------------------------
	function automatic logic [31:0] gpr_read(input logic [3:0] idx);
		logic [31:0] v;
		v = idx[3] ? high_regs[idx[2:0]]
			: (use_bank1 ? low_bank1[idx[2:0]] : low_bank0[idx[2:0]]);
		return v;
	endfunction

	// A continuous assign would not wake on the arrays the function reads
	always_comb begin
		gpr_rd_a = gpr_read(gpr_rd_a_idx);
		gpr_rd_b = gpr_read(gpr_rd_b_idx);
	end
	assign gpr_en_b0 = gpr_wr.en & ~gpr_wr.idx[3] & ~use_bank1;
	assign gpr_en_b1 = gpr_wr.en & ~gpr_wr.idx[3] & use_bank1;

	// Other-bank slot is only writable by privileged control loads
	logic alt_wr;
	assign alt_wr = ctrl_wr.en & (ctrl_wr.sel == BCR_CR_ALT_BANK) & privilege_bit;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_gpr
			assign bank1_flat[32*g +: 32] = low_bank1[g];
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					low_bank0[g] <= `BCR_ZERO;
					low_bank1[g] <= `BCR_ZERO;
					high_regs[g] <= `BCR_ZERO;
				end else begin
					if (gpr_en_b0 && gpr_wr.idx[2:0] == 3'(g))
						low_bank0[g] <= gpr_wr.data;
					else if (alt_wr && use_bank1 && ctrl_wr.alt_idx == 3'(g))
						low_bank0[g] <= ctrl_wr.data;
					if (gpr_en_b1 && gpr_wr.idx[2:0] == 3'(g))
						low_bank1[g] <= gpr_wr.data;
					else if (alt_wr && !use_bank1 && ctrl_wr.alt_idx == 3'(g))
						low_bank1[g] <= ctrl_wr.data;
					if (gpr_wr.en && gpr_wr.idx == {1'b1, 3'(g)})
						high_regs[g] <= gpr_wr.data;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Floating-point registers
	// ------------------------------------------------------------
	generate
		for (g = 0; g < 16; g++) begin : g_fpr
			logic hit;
			logic to_bank1;
			assign hit = fpr_wr.en && fpr_wr.idx == 4'(g);
			assign to_bank1 = fpr_wr.ext ? ~sel_fp1 : sel_fp1;
			assign fpr_sel[g] = sel_fp1 ? fpr_bank1[g] : fpr_bank0[g];
			assign fpr_ext[g] = sel_fp1 ? fpr_bank0[g] : fpr_bank1[g];
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					fpr_bank0[g] <= `BCR_ZERO;
					fpr_bank1[g] <= `BCR_ZERO;
				end else if (hit) begin
					if (to_bank1)
						fpr_bank1[g] <= fpr_wr.data;
					else
						fpr_bank0[g] <= fpr_wr.data;
				end
			end
			assign extended_fp_matrix_rd[32*g +: 32] = fpr_ext[g];
		end
	endgenerate

	assign fpr_rd = fpr_rd_ext ? fpr_ext[fpr_rd_idx] : fpr_sel[fpr_rd_idx];
	assign dbl_rd = dbl_rd_ext
		? {fpr_ext[{dbl_rd_idx, 1'b0}], fpr_ext[{dbl_rd_idx, 1'b1}]}
		: {fpr_sel[{dbl_rd_idx, 1'b0}], fpr_sel[{dbl_rd_idx, 1'b1}]};
	assign vec_rd = {fpr_sel[{vec_rd_idx, 2'b00}], fpr_sel[{vec_rd_idx, 2'b01}],
		fpr_sel[{vec_rd_idx, 2'b10}], fpr_sel[{vec_rd_idx, 2'b11}]};

	// ------------------------------------------------------------
	// Control and system registers
	// ------------------------------------------------------------
	logic ctrl_ok;
	logic priv_only;
	assign priv_only = ctrl_wr.sel inside {BCR_CR_SAVED_STATUS, BCR_CR_SAVED_IP,
		BCR_CR_VECTOR_BASE, BCR_CR_SAVED_STACK, BCR_CR_DEBUG_BASE, BCR_CR_ALT_BANK};
	assign ctrl_ok = ctrl_wr.en & (privilege_bit | ~priv_only);
	assign ctrl_priv_err = ctrl_wr.en & priv_only & ~privilege_bit;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_word <= {1'b0, 1'b1, 1'b1, 29'h0};
		end else if (exc_take) begin
			status_word[`BCR_SW_PRIV] <= 1'b1;
			status_word[`BCR_SW_BANK] <= 1'b1;
		end else if (exc_return) begin
			status_word <= saved_status_copy;
		end else if (ctrl_wr.en && ctrl_wr.sel == BCR_CR_STATUS) begin
			// User writes leave the protected fields alone
			if (privilege_bit)
				status_word <= ctrl_wr.data;
			else
				status_word[27:0] <= ctrl_wr.data[27:0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			saved_status_copy <= `BCR_ZERO;
			saved_instruction_address <= `BCR_ZERO;
			saved_stack_pointer_copy <= `BCR_ZERO;
		end else if (exc_take) begin
			saved_status_copy <= status_word;
			saved_instruction_address <= exc_addr;
			saved_stack_pointer_copy <= high_regs[7];
		end else if (ctrl_ok) begin
			if (ctrl_wr.sel == BCR_CR_SAVED_STATUS)
				saved_status_copy <= ctrl_wr.data;
			if (ctrl_wr.sel == BCR_CR_SAVED_IP)
				saved_instruction_address <= ctrl_wr.data;
			if (ctrl_wr.sel == BCR_CR_SAVED_STACK)
				saved_stack_pointer_copy <= ctrl_wr.data;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			exception_vector_base <= `BCR_VBR_RESET;
			global_base_address <= `BCR_ZERO;
			debug_handler_base <= `BCR_ZERO;
			accumulator_high <= `BCR_ZERO;
			accumulator_low <= `BCR_ZERO;
			fp_cpu_transfer <= `BCR_ZERO;
		end else if (ctrl_ok) begin
			case (ctrl_wr.sel)
				BCR_CR_VECTOR_BASE: exception_vector_base <= ctrl_wr.data;
				BCR_CR_GLOBAL_BASE: global_base_address <= ctrl_wr.data;
				BCR_CR_DEBUG_BASE: debug_handler_base <= ctrl_wr.data;
				BCR_CR_ACC_HIGH: accumulator_high <= ctrl_wr.data;
				BCR_CR_ACC_LOW: accumulator_low <= ctrl_wr.data;
				BCR_CR_FP_TRANSFER: fp_cpu_transfer <= ctrl_wr.data;
				default: ;
			endcase
		end
	end

	// Call wins over a software write landing in the same cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			subroutine_return_address <= `BCR_ZERO;
		else if (call_take)
			subroutine_return_address <= call_return_addr;
		else if (ctrl_ok && ctrl_wr.sel == BCR_CR_RETURN_LINK)
			subroutine_return_address <= ctrl_wr.data;
	end
	assign return_target = subroutine_return_address;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			instruction_pointer <= `BCR_PC_RESET;
		else if (ip_load)
			instruction_pointer <= ip_next;
	end

	always_comb begin
		case (ctrl_rd_sel)
			BCR_CR_SAVED_STATUS: ctrl_rd = saved_status_copy;
			BCR_CR_SAVED_IP: ctrl_rd = saved_instruction_address;
			BCR_CR_GLOBAL_BASE: ctrl_rd = global_base_address;
			BCR_CR_VECTOR_BASE: ctrl_rd = exception_vector_base;
			BCR_CR_SAVED_STACK: ctrl_rd = saved_stack_pointer_copy;
			BCR_CR_DEBUG_BASE: ctrl_rd = debug_handler_base;
			BCR_CR_ACC_HIGH: ctrl_rd = accumulator_high;
			BCR_CR_ACC_LOW: ctrl_rd = accumulator_low;
			BCR_CR_RETURN_LINK: ctrl_rd = subroutine_return_address;
			BCR_CR_FP_TRANSFER: ctrl_rd = fp_cpu_transfer;
			BCR_CR_STATUS: ctrl_rd = status_word;
			BCR_CR_ALT_BANK: ctrl_rd = use_bank1 ? low_bank0[ctrl_rd_alt_idx]
				: low_bank1[ctrl_rd_alt_idx];
			default: ctrl_rd = `BCR_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Exception target, addressing and memory checks
	// ------------------------------------------------------------
	assign exc_target = (exc_user_break && user_break_debug_enable)
		? debug_handler_base
		: exception_vector_base + exc_offset;
	assign base_ea = global_base_address + base_disp;

	logic misaligned;
	logic upper_user;
	always_comb begin
		case (mem_chk.size)
			BCR_SZ_WORD: misaligned = mem_chk.addr[0];
			BCR_SZ_LONG: misaligned = |mem_chk.addr[1:0];
			default: misaligned = 1'b0;
		endcase
	end
	assign upper_user = (mem_chk.addr >= `BCR_UPPER_WIN_LO) & ~privilege_bit;
	assign mem_addr_err = mem_chk.valid & (misaligned | upper_user);
	// Upper window or lower alias window; only translated, right-size accesses are defined there
	assign mem_in_reg_window = mem_chk.valid & ((mem_chk.addr >= `BCR_UPPER_WIN_LO)
		| (mem_chk.addr >= `BCR_LOWER_WIN_LO && mem_chk.addr <= `BCR_LOWER_WIN_HI));

	always_comb begin
		case (load_size)
			BCR_SZ_BYTE: load_data = {{24{load_raw[7]}}, load_raw[7:0]};
			BCR_SZ_WORD: load_data = {{16{load_raw[15]}}, load_raw[15:0]};
			default: load_data = load_raw;
		endcase
	end

	// Strap is caught by a clock edge while power-on reset is low, then frozen
	always_ff @(posedge mclk) begin
		if (!por_n)
			big_endian <= big_endian_strap;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_exc;
		exc_take && !exc_return;
	endsequence
	property p_save_status;
		@(posedge mclk) disable iff (!reset_n) s_exc |=> saved_status_copy == $past(status_word);
	endproperty
	a_save_status: assert property (p_save_status) else $error("saved status wrong");
	property p_save_ip;
		@(posedge mclk) disable iff (!reset_n) exc_take |=> saved_instruction_address == $past(exc_addr);
	endproperty
	a_save_ip: assert property (p_save_ip) else $error("saved ip wrong");
	property p_save_stack;
		@(posedge mclk) disable iff (!reset_n)
			exc_take |=> saved_stack_pointer_copy == $past(high_regs[7]);
	endproperty
	a_save_stack: assert property (p_save_stack) else $error("saved stack wrong");
	property p_priv_entry;
		@(posedge mclk) disable iff (!reset_n) exc_take |=> privilege_bit && bank_select_bit;
	endproperty
	a_priv_entry: assert property (p_priv_entry) else $error("no privilege after exception");
	property p_link;
		@(posedge mclk) disable iff (!reset_n) call_take |=> return_target == $past(call_return_addr);
	endproperty
	a_link: assert property (p_link) else $error("return link not written");
	property p_align;
		@(posedge mclk) disable iff (!reset_n)
			mem_chk.valid && mem_chk.size == BCR_SZ_LONG && mem_chk.addr[1:0] != 2'b00 |-> mem_addr_err;
	endproperty
	a_align: assert property (p_align) else $error("misaligned long not flagged");
	property p_user_window;
		@(posedge mclk) disable iff (!reset_n)
			mem_chk.valid && !privilege_bit && mem_chk.addr[31:26] == 6'h3F |-> mem_addr_err;
	endproperty
	a_user_window: assert property (p_user_window) else $error("user window not flagged");
	property p_bank1_hidden;
		@(posedge mclk) disable iff (!reset_n)
			gpr_wr.en && !privilege_bit && !gpr_wr.idx[3] |=> $stable(bank1_flat);
	endproperty
	a_bank1_hidden: assert property (p_bank1_hidden) else $error("bank 1 written in user mode");
	property p_ext_bank;
		@(posedge mclk) disable iff (!reset_n)
			fpr_rd == (fpr_rd_ext ^ sel_fp1 ? fpr_bank1[fpr_rd_idx] : fpr_bank0[fpr_rd_idx]);
	endproperty
	a_ext_bank: assert property (p_ext_bank) else $error("fp bank mapping wrong");

endmodule

// ### bcr_core_model.sv
module bcr_core_model
	import bcr_pkg::*;
(
	// Clock and refusal flag
	input wire logic mclk,
	input wire logic ctrl_priv_err,
	// Register writes
	output bcr_gpr_wr_t gpr_wr,
	output bcr_fpr_wr_t fpr_wr,
	output bcr_ctrl_wr_t ctrl_wr,
	// Flow events
	output logic exc_take,
	output logic [31:0] exc_addr,
	output logic exc_return,
	output logic ip_load,
	output logic [31:0] ip_next,
	output logic call_take,
	output logic [31:0] call_return_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_err;
	// Only register writes and flow events are issued; window addresses are checked, never accessed
	initial begin
		gpr_wr = '0;
		fpr_wr = '0;
		ctrl_wr = '0;
		{exc_take, exc_return, ip_load, call_take} = '0;
		{exc_addr, ip_next, call_return_addr} = '0;
		last_err = 1'b0;
	end
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	// Payloads are inverted on release so a stale value never looks fresh
	task automatic wr_gpr(input logic [3:0] i, input logic [31:0] d);
		step();
		gpr_wr = '{1'b1, i, d};
		step();
		gpr_wr = '{1'b0, ~i, ~d};
	endtask
	task automatic wr_fpr(input logic x, input logic [3:0] i, input logic [31:0] d);
		step();
		fpr_wr = '{1'b1, x, i, d};
		step();
		fpr_wr = '{1'b0, x, ~i, ~d};
	endtask
	task automatic wr_ctrl(input bcr_ctrl_sel_t s, input logic [2:0] a, input logic [31:0] d);
		step();
		ctrl_wr = '{1'b1, s, a, d};
		#5;
		last_err = ctrl_priv_err;
		step();
		ctrl_wr = '{1'b0, s, ~a, ~d};
	endtask
	task automatic exc(input logic [31:0] a);
		step();
		exc_take = 1'b1;
		exc_addr = a;
		step();
		exc_take = 1'b0;
		exc_addr = ~a;
	endtask
	task automatic ret();
		step();
		exc_return = 1'b1;
		step();
		exc_return = 1'b0;
	endtask
	task automatic call(input logic [31:0] a);
		step();
		call_take = 1'b1;
		call_return_addr = a;
		step();
		call_take = 1'b0;
		call_return_addr = ~a;
	endtask
	task automatic ipl(input logic [31:0] a);
		step();
		ip_load = 1'b1;
		ip_next = a;
		step();
		ip_load = 1'b0;
		ip_next = ~a;
	endtask
endmodule

// ### banked_cpu_register_file_bench.sv
module banked_cpu_register_file_bench
	import bcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk = 1'b0;
	logic reset_n, por_n, big_endian_strap, fp_bank_select, fpr_rd_ext, dbl_rd_ext;
	logic exc_user_break, user_break_debug_enable, ctrl_priv_err, mem_addr_err;
	logic mem_in_reg_window, big_endian, exc_take, exc_return, ip_load, call_take;
	logic [3:0] gpr_rd_a_idx, gpr_rd_b_idx, fpr_rd_idx;
	logic [2:0] dbl_rd_idx, ctrl_rd_alt_idx;
	logic [1:0] vec_rd_idx;
	logic [31:0] gpr_rd_a, gpr_rd_b, fpr_rd, ctrl_rd, status_word, exc_addr, exc_offset;
	logic [31:0] exc_target, ip_next, instruction_pointer, call_return_addr, return_target;
	logic [31:0] base_disp, base_ea, load_raw, load_data;
	logic [63:0] dbl_rd;
	logic [127:0] vec_rd;
	logic [511:0] extended_fp_matrix_rd;
	bcr_gpr_wr_t gpr_wr;
	bcr_fpr_wr_t fpr_wr;
	bcr_ctrl_wr_t ctrl_wr;
	bcr_ctrl_sel_t ctrl_rd_sel;
	bcr_mem_chk_t mem_chk;
	bcr_size_t load_size;
	int miscompares = 0;
	int cmp_count = 0;
	always #10 mclk = ~mclk;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	bcr_regfile bcr_regfile_i (.mclk, .reset_n, .por_n, .big_endian_strap, .gpr_rd_a_idx,
		.gpr_rd_b_idx, .gpr_rd_a, .gpr_rd_b, .gpr_wr, .fp_bank_select, .fpr_rd_idx,
		.fpr_rd_ext, .fpr_rd, .dbl_rd_idx, .dbl_rd_ext, .dbl_rd, .vec_rd_idx, .vec_rd,
		.extended_fp_matrix_rd, .fpr_wr, .ctrl_wr, .ctrl_rd_sel, .ctrl_rd_alt_idx, .ctrl_rd,
		.ctrl_priv_err, .status_word, .exc_take, .exc_user_break, .exc_addr, .exc_offset,
		.exc_target, .exc_return, .ip_load, .ip_next, .instruction_pointer, .call_take,
		.call_return_addr, .return_target, .user_break_debug_enable, .base_disp, .base_ea,
		.mem_chk, .mem_addr_err, .mem_in_reg_window, .load_raw, .load_size, .load_data,
		.big_endian);
	bcr_core_model bcr_core_model_i (.mclk, .ctrl_priv_err, .gpr_wr, .fpr_wr, .ctrl_wr,
		.exc_take, .exc_addr, .exc_return, .ip_load, .ip_next, .call_take, .call_return_addr);
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk(input string what, input logic [511:0] seen, input logic [511:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic rdc(input bcr_ctrl_sel_t s, input logic [31:0] exp);
		ctrl_rd_sel = s;
		#1;
		chk(s.name(), ctrl_rd, exp);
	endtask
	task automatic mchk(input logic [31:0] a, input bcr_size_t z, input logic e);
		mem_chk = '{1'b1, a, z};
		#1;
		chk("addr err", mem_addr_err, e);
	endtask
	task automatic lchk(input logic [31:0] raw, input bcr_size_t z, input logic [31:0] exp);
		load_raw = raw;
		load_size = z;
		#1;
		chk("load", load_data, exp);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdc(BCR_CR_VECTOR_BASE, 32'h0000_0000);
		chk("status", status_word, 32'h6000_0000);
		chk("ip", instruction_pointer, 32'hA000_0000);
		$display("test reset done");
	endtask
	task automatic t_regs();
		for (int s = 1; s <= 10; s++) begin
			bcr_core_model_i.wr_ctrl(bcr_ctrl_sel_t'(s), 3'h0, 32'hA5A5_0000 | 32'(s));
		end
		for (int s = 1; s <= 10; s++) begin
			rdc(bcr_ctrl_sel_t'(s), 32'hA5A5_0000 | 32'(s));
		end
		base_disp = 32'h0000_0040;
		#1;
		chk("base ea", base_ea, 32'hA5A5_0043);
		exc_offset = 32'h0000_0100;
		#1;
		chk("target", exc_target, 32'hA5A5_0104);
		exc_user_break = 1'b1;
		user_break_debug_enable = 1'b1;
		#1;
		chk("debug target", exc_target, 32'hA5A5_0006);
		user_break_debug_enable = 1'b0;
		#1;
		chk("break target", exc_target, 32'hA5A5_0104);
		exc_user_break = 1'b0;
		bcr_core_model_i.call(32'h0C00_0100);
		chk("return", return_target, 32'h0C00_0100);
		rdc(BCR_CR_RETURN_LINK, 32'h0C00_0100);
		bcr_core_model_i.ipl(32'h8C00_0000);
		chk("ip", instruction_pointer, 32'h8C00_0000);
		mchk(32'hFC00_0000, BCR_SZ_LONG, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_fp();
		for (int i = 4; i < 8; i++) begin
			bcr_core_model_i.wr_fpr(1'b0, 4'(i), 32'hF000_0000 | 32'(i));
		end
		bcr_core_model_i.wr_fpr(1'b1, 4'h5, 32'hE000_0005);
		fpr_rd_idx = 4'h5;
		#1;
		chk("single", fpr_rd, 32'hF000_0005);
		fpr_rd_ext = 1'b1;
		#1;
		chk("ext single", fpr_rd, 32'hE000_0005);
		dbl_rd_idx = 3'h2;
		dbl_rd_ext = 1'b1;
		#1;
		chk("ext pair", dbl_rd, {32'h0000_0000, 32'hE000_0005});
		dbl_rd_ext = 1'b0;
		vec_rd_idx = 2'h1;
		#1;
		chk("pair", dbl_rd, {32'hF000_0004, 32'hF000_0005});
		chk("quad", vec_rd, {32'hF000_0004, 32'hF000_0005, 32'hF000_0006, 32'hF000_0007});
		chk("matrix", extended_fp_matrix_rd[191:160], 32'hE000_0005);
		fp_bank_select = 1'b1;
		fpr_rd_ext = 1'b0;
		#1;
		chk("single b1", fpr_rd, 32'hE000_0005);
		fpr_rd_ext = 1'b1;
		#1;
		chk("ext b0", fpr_rd, 32'hF000_0005);
		chk("matrix b0", extended_fp_matrix_rd[159:128], 32'hF000_0004);
		$display("test fp done");
	endtask
	task automatic t_banks();
		gpr_rd_a_idx = 4'h3;
		gpr_rd_b_idx = 4'hF;
		bcr_core_model_i.wr_gpr(4'h3, 32'hB1B1_0003);
		bcr_core_model_i.wr_gpr(4'hF, 32'h1234_5678);
		bcr_core_model_i.wr_ctrl(BCR_CR_STATUS, 3'h0, 32'h4000_0000);
		#1;
		chk("bank0 r3", gpr_rd_a, 32'h0000_0000);
		bcr_core_model_i.wr_gpr(4'h3, 32'hB0B0_0003);
		ctrl_rd_alt_idx = 3'h3;
		rdc(BCR_CR_ALT_BANK, 32'hB1B1_0003);
		bcr_core_model_i.wr_ctrl(BCR_CR_STATUS, 3'h0, 32'h0000_0000);
		#1;
		chk("user r3", gpr_rd_a, 32'hB0B0_0003);
		chk("status", status_word, 32'h0000_0000);
		bcr_core_model_i.wr_gpr(4'h2, 32'hC0C0_0002);
		bcr_core_model_i.wr_ctrl(BCR_CR_ALT_BANK, 3'h3, 32'hDEAD_0003);
		chk("alt refused", bcr_core_model_i.last_err, 1'b1);
		bcr_core_model_i.wr_ctrl(BCR_CR_VECTOR_BASE, 3'h0, 32'h0000_0000);
		chk("base refused", bcr_core_model_i.last_err, 1'b1);
		rdc(BCR_CR_VECTOR_BASE, 32'hA5A5_0004);
		bcr_core_model_i.exc(32'h0C00_0010);
		#1;
		chk("mode bits", status_word[30:29], 2'b11);
		chk("bank1 r3", gpr_rd_a, 32'hB1B1_0003);
		chk("r15", gpr_rd_b, 32'h1234_5678);
		rdc(BCR_CR_SAVED_STATUS, 32'h0000_0000);
		rdc(BCR_CR_SAVED_IP, 32'h0C00_0010);
		rdc(BCR_CR_SAVED_STACK, 32'h1234_5678);
		ctrl_rd_alt_idx = 3'h2;
		rdc(BCR_CR_ALT_BANK, 32'hC0C0_0002);
		bcr_core_model_i.ret();
		#1;
		chk("status back", status_word, 32'h0000_0000);
		chk("r3 back", gpr_rd_a, 32'hB0B0_0003);
		$display("test banks done");
	endtask
	task automatic t_mem();
		mchk(32'h0000_0101, BCR_SZ_BYTE, 1'b0);
		mchk(32'h0000_0102, BCR_SZ_WORD, 1'b0);
		mchk(32'h0000_0103, BCR_SZ_WORD, 1'b1);
		mchk(32'h0000_0104, BCR_SZ_LONG, 1'b0);
		mchk(32'h0000_0106, BCR_SZ_LONG, 1'b1);
		mchk(32'hFC00_0004, BCR_SZ_LONG, 1'b1);
		mchk(32'h1C00_0000, BCR_SZ_LONG, 1'b0);
		chk("window", mem_in_reg_window, 1'b1);
		mchk(32'h0000_0100, BCR_SZ_LONG, 1'b0);
		chk("no window", mem_in_reg_window, 1'b0);
		lchk(32'h0000_0080, BCR_SZ_BYTE, 32'hFFFF_FF80);
		lchk(32'h1234_7FFF, BCR_SZ_WORD, 32'h0000_7FFF);
		lchk(32'h0000_8001, BCR_SZ_WORD, 32'hFFFF_8001);
		lchk(32'h8000_0001, BCR_SZ_LONG, 32'h8000_0001);
		$display("test mem done");
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{reset_n, por_n, fp_bank_select, fpr_rd_ext, dbl_rd_ext} = '0;
		{exc_user_break, user_break_debug_enable} = '0;
		big_endian_strap = 1'b1;
		{gpr_rd_a_idx, gpr_rd_b_idx, fpr_rd_idx, dbl_rd_idx, ctrl_rd_alt_idx, vec_rd_idx} = '0;
		{exc_offset, base_disp, load_raw} = '0;
		ctrl_rd_sel = BCR_CR_NONE;
		mem_chk = '0;
		load_size = BCR_SZ_BYTE;
		repeat (3) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		por_n = 1'b1;
		big_endian_strap = 1'b0;
		t_reset();
		t_regs();
		t_fp();
		t_banks();
		t_mem();
		chk("endian", big_endian, 1'b1);
		complete_run();
	end
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule
